// ===== dv/header_sink.sv
// Purpose: Downstream unpacking stage that takes decoded headers
// Assumes: A header is taken on every hdr_valid cycle, no back-pressure
// Notes: Keeps a count and the last header for the bench
`timescale 1ns/10ps
module header_sink (
    input wire logic core_clk, // Clock
    input wire logic rst_b, // Async reset, active low
    input wire logic hdr_valid, // Header present
    input wire tbhd_pkg::hdr_info_t hdr, // Header fields
    output int n_seen, // Headers taken
    output tbhd_pkg::hdr_info_t last_r // Last header taken
);
    import tbhd_pkg::*;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            n_seen <= 0;
            last_r <= '0;
        end else if (hdr_valid) begin
            n_seen <= n_seen + 1;
            last_r <= hdr;
        end
    end
endmodule : header_sink

// ===== dv/texture_block_header_decoder_test.sv
// Purpose: Self-checking bench for the texture block header decoder
// Assumes: 2D and 3D decode modelled in full
// Notes: Model result queued per block, compared one cycle later
`timescale 1ns/10ps
module texture_block_header_decoder_test;
    import tbhd_pkg::*;
    logic core_clk;
    logic rst_b;
    logic blk_valid;
    logic [127:0] blk_word;
    logic is_3d;
    footprint_t footprint;
    logic hdr_valid;
    hdr_info_t hdr;
    hdr_info_t exp_h = '0;
    hdr_info_t sink_last;
    hdr_info_t expq[$];
    logic expv;
    int n_seen;
    int n_sent;
    int n_errors;
    int n_checks;
    int seed = 32'had47;
    int i;
    int k;

    texture_block_header_decoder texture_block_header_decoder_i (.core_clk(core_clk), .rst_b(rst_b),
        .blk_valid(blk_valid), .blk_word(blk_word), .is_3d(is_3d), .footprint(footprint),
        .hdr_valid(hdr_valid), .hdr(hdr));
    header_sink header_sink_i (.core_clk(core_clk), .rst_b(rst_b), .hdr_valid(hdr_valid), .hdr(hdr),
        .n_seen(n_seen), .last_r(sink_last));

    function automatic hdr_info_t model(input logic [127:0] wd, input logic d3, input footprint_t fp);
        hdr_info_t e;
        int lo[8] = '{0, 0, 1, 2, 3, 4, 5, 7};
        int hi[8] = '{0, 0, 9, 11, 15, 19, 23, 31};
        int w, h, dd, a, b, c, r, m, t, q, lim;
        logic dl, hp;
        e = '0;
        e.part_count = 3'(wd[12:11]) + 3'h1;
        if (wd[8:0] == 9'h1fc) begin
            e.is_void = 1'b1;
            return e;
        end
        if (wd[3:0] == 4'h0 || (wd[8:6] == 3'h7 && wd[1:0] == 2'h0)) begin
            e.is_reserved = 1'b1;
            e.nan_result = (wd[3:0] == 4'h0);
            return e;
        end
        a = wd[6:5];
        b = wd[8:7];
        c = wd[10:9];
        dl = wd[10];
        hp = wd[9];
        dd = 1;
        lim = d3 ? 5 : 12;
        r = (wd[1:0] != 2'h0) ? {wd[1:0], wd[4]} : {wd[3:2], wd[4]};
        if (d3 && wd[1:0] != 2'h0) begin
            w = a + 2;
            h = b + 2;
            dd = wd[3:2] + 2;
        end else if (d3 && b != 3) begin
            w = (b == 0) ? 6 : a + 2;
            h = (b == 1) ? 6 : c + 2;
            dd = (b == 2) ? 6 : (b == 0) ? a + 2 : c + 2;
            dl = 1'b0;
            hp = 1'b0;
        end else if (d3) begin
            w = (a == 0) ? 6 : 2;
            h = (a == 1) ? 6 : 2;
            dd = (a == 2) ? 6 : 2;
        end else if (wd[1:0] != 2'h0) begin
            case (wd[3:2])
                2'h0: begin
                    w = b + 4;
                    h = a + 2;
                end
                2'h1: begin
                    w = b + 8;
                    h = a + 2;
                end
                2'h2: begin
                    w = a + 2;
                    h = b + 8;
                end
                default: begin
                    w = wd[8] ? wd[7] + 2 : a + 2;
                    h = wd[8] ? a + 2 : wd[7] + 6;
                end
            endcase
        end else begin
            case (b)
                0: begin
                    w = 12;
                    h = a + 2;
                end
                1: begin
                    w = a + 2;
                    h = 12;
                end
                3: begin
                    w = wd[5] ? 10 : 6;
                    h = wd[5] ? 6 : 10;
                end
                default: begin
                    w = a + 6;
                    h = c + 6;
                    dl = 1'b0;
                    hp = 1'b0;
                end
            endcase
        end
        m = hp ? hi[r] : lo[r];
        t = ((m + 1) % 3 == 0);
        q = ((m + 1) % 5 == 0);
        e.grid_w = 4'(w);
        e.grid_h = 4'(h);
        e.grid_d = 4'(dd);
        e.dual_plane = dl;
        e.high_prec = hp;
        e.range.max = 5'(m);
        e.range.trits = 1'(t);
        e.range.quints = 1'(q);
        e.range.plain_bits = 3'($clog2((m + 1) / (t ? 3 : q ? 5 : 1)));
        e.range.invalid = (r < 2);
        e.endpoint_pairs = e.part_count;
        e.is_error = (dl && wd[12:11] == 2'h3) || r < 2 || w > fp.w || h > fp.h || dd > fp.d
            || w > lim || h > lim || dd > lim;
        e.nan_result = (w * h * dd * (dl ? 2 : 1)) > 64;
        if (wd[12:11] != 2'h0) begin
            e.pattern_sel = wd[22:13];
        end else begin
            e.color_endpoint_mode = wd[16:13];
            e.channel_sel = dl ? wd[18:17] : 2'h0;
            e.channel_mask = dl ? 4'h1 << wd[18:17] : 4'h0;
        end
        return e;
    endfunction : model

    function automatic logic [127:0] rword();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction : rword

    function automatic footprint_t rand_fp(input logic d3);
        int sz[6] = '{4, 5, 6, 8, 10, 12};
        footprint_t f;
        f.w = 4'(sz[$unsigned($random(seed)) % 6]);
        f.h = 4'(sz[$unsigned($random(seed)) % 6]);
        f.d = 4'h1;
        if (d3) begin
            f.w = 4'(3 + $unsigned($random(seed)) % 4);
            f.h = 4'(3 + $unsigned($random(seed)) % 4);
            f.d = 4'(3 + $unsigned($random(seed)) % 4);
        end
        return f;
    endfunction : rand_fp

    task automatic check(input string what, input logic [63:0] e, input logic [63:0] s);
        n_checks++;
        if (e !== s) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic send(input logic [127:0] wd, input logic d3, input footprint_t fp);
        @(posedge core_clk);
        blk_valid <= 1'b1;
        blk_word <= wd;
        is_3d <= d3;
        footprint <= fp;
        expq.push_back(model(wd, d3, fp));
        n_sent++;
    endtask : send

    task automatic idle();
        @(posedge core_clk);
        blk_valid <= 1'b0;
        blk_word <= ~blk_word;
    endtask : idle

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            expv <= 1'b0;
        end else begin
            expv <= blk_valid;
        end
    end

    always @(negedge core_clk) begin
        if (rst_b) begin
            check("hdr_valid", 64'(expv), 64'(hdr_valid));
            if (expv && expq.size() > 0) begin
                exp_h = expq.pop_front();
            end
            // Between blocks the last header must hold
            check("hdr", 64'(exp_h), 64'(hdr));
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        give_verdict();
    end

    initial begin
        rst_b = 1'b0;
        blk_valid = 1'b0;
        blk_word = '0;
        is_3d = 1'b0;
        footprint = '0;
        n_sent = 0;
        repeat (16) @(posedge core_clk);
        check("hdr_rst", 64'h0, 64'(hdr));
        check("hdr_valid_rst", 64'h0, 64'(hdr_valid));
        rst_b <= 1'b1;
        $display("test reset done");
        // Every mode field value in 2D then 3D, back to back
        for (i = 0; i < 4096; i++) begin
            send((rword() & ~128'h7ff) | 128'(i[10:0]), i[11], rand_fp(i[11]));
        end
        $display("test mode sweep done");
        // Random blocks with gaps, void and low-zero words in both dimensions
        for (i = 0; i < 600; i++) begin
            k = $unsigned($random(seed)) % 4;
            if (k == 0) begin
                idle();
            end else if (k == 1) begin
                send(i[1] ? (rword() & ~128'h1ff) | 128'h1fc : rword() & ~128'hf, i[0], rand_fp(i[0]));
            end else begin
                send(rword(), k[0], rand_fp(k[0]));
            end
        end
        idle();
        repeat (3) @(posedge core_clk);
        check("blocks", 64'(n_sent), 64'(n_seen));
        check("queue", 64'h0, 64'(expq.size()));
        check("last_hdr", 64'(exp_h), 64'(sink_last));
        $display("test random done");
        give_verdict();
    end
endmodule : texture_block_header_decoder_test

// ===== src/range_decode.sv
// Purpose: Index range lookup from range code and precision bit
// Assumes: Pure combinational, same clock as its user
// Notes: Codes 000 and 001 flag invalid
`timescale 1ns/10ps
module range_decode (
    input wire logic [2:0] rcode, // r2 r1 r0
    input wire logic prec, // High precision group
    output tbhd_pkg::range_info_t info // Range and encoding counts
);
    import tbhd_pkg::*;

    always_comb begin
        info = '0;
        unique case (rcode)
            3'h0, 3'h1: begin
                info.invalid = 1'b1;
            end
            3'h2: begin
                info.max = prec ? 5'h09 : 5'h01;
                info.quints = prec;
                info.plain_bits = 3'h1;
            end
            3'h3: begin
                info.max = prec ? 5'h0b : 5'h02;
                info.trits = 1'b1;
                info.plain_bits = prec ? 3'h2 : 3'h0;
            end
            3'h4: begin
                info.max = prec ? 5'h0f : 5'h03;
                info.plain_bits = prec ? 3'h4 : 3'h2;
            end
            3'h5: begin
                info.max = prec ? 5'h13 : 5'h04;
                info.quints = 1'b1;
                info.plain_bits = prec ? 3'h2 : 3'h0;
            end
            3'h6: begin
                info.max = prec ? 5'h17 : 5'h05;
                info.trits = 1'b1;
                info.plain_bits = prec ? 3'h3 : 3'h1;
            end
            3'h7: begin
                info.max = prec ? 5'h1f : 5'h07;
                info.plain_bits = prec ? 3'h5 : 3'h3;
            end
        endcase
    end

endmodule : range_decode

// ===== src/tbhd_defines.svh
// Purpose: Field positions and fixed values of the texture block header
// Assumes: 128-bit block word, bit 0 is the least significant
// Notes: Definitions only
`ifndef TBHD_DEFINES_SVH
`define TBHD_DEFINES_SVH

`define MODE_MSB 10
`define MODE_LSB 0
`define PART_MSB 12
`define PART_LSB 11
`define PSEL_MSB 22
`define PSEL_LSB 13
`define ENDPT_MODE_MSB 16
`define ENDPT_MODE_LSB 13
`define CSEL_MSB 18
`define CSEL_LSB 17
`define VOID_PATTERN 9'h1fc
`define MAX_INDICES 13'h0040
`define DIM_MIN 4'h2
`define DIM_MAX_2D 4'hc
`define DIM_MAX_3D 4'h5
`define HDR_VALID_RST 1'b0

`endif

// ===== src/tbhd_pkg.sv
// Purpose: Types shared by the texture block header decoder
// Assumes: Grid dimensions fit in four bits
// Notes: None
package tbhd_pkg;

    typedef struct packed {
        logic [3:0] w;
        logic [3:0] h;
        logic [3:0] d;
    } footprint_t;

    typedef struct packed {
        logic [3:0] w;
        logic [3:0] h;
        logic [3:0] d;
        logic dual;
        logic prec;
        logic [2:0] rcode;
    } grid_t;

    typedef struct packed {
        logic [4:0] max;
        logic trits;
        logic quints;
        logic [2:0] plain_bits;
        logic invalid;
    } range_info_t;

    typedef struct packed {
        logic [3:0] grid_w;
        logic [3:0] grid_h;
        logic [3:0] grid_d;
        logic dual_plane;
        logic high_prec;
        range_info_t range;
        logic [2:0] part_count;
        logic [9:0] pattern_sel;
        logic [3:0] color_endpoint_mode;
        logic [1:0] channel_sel;
        logic [3:0] channel_mask;
        logic [2:0] endpoint_pairs;
        logic is_void;
        logic is_reserved;
        logic is_error;
        logic nan_result;
    } hdr_info_t;

endpackage : tbhd_pkg

// ===== src/texture_block_header_decoder.sv
// Purpose: Decode control fields of a 128-bit compressed texture block
// Assumes: One block word per blk_valid cycle, footprint stable with it
// Notes: One cycle latency, outputs registered
`timescale 1ns/10ps
`include "tbhd_defines.svh"

// Overview of operation
// - Mode field is bits 10:0, derives grid
// - Partition count is bits 12:11 plus one
// - Multi-partition uses ten-bit pattern selector 22:13
// - One endpoint pair per partition, non-void
// - Single partition: mode 16:13, select 18:17
// - Top mode bit dual; dual with four errors
// - Range code r2 r1 r0; 000,001 invalid
// - Range maxima per code and precision
// - Report trits, quints and plain bits
// - Grid 2..12 in 2D, 2..5 in 3D
// - Grid above footprint is illegal, error color
// - 2D low bits nonzero: shapes from bits 3:2
// - 2D bits 3:2 eleven: bit 8 picks shape
// - Void-extent pattern and reserved neighbours
// - Low four mode bits zero give NaN
// - Channel select names second-plane component
module texture_block_header_decoder (
    input wire logic core_clk, // 25 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic blk_valid, // Block word present
    input wire logic [127:0] blk_word, // Fetched block word
    input wire logic is_3d, // Texture uses 3D blocks
    input wire tbhd_pkg::footprint_t footprint, // Block footprint in texels
    output logic hdr_valid, // Decoded header present
    output tbhd_pkg::hdr_info_t hdr // Decoded header fields
);
    import tbhd_pkg::*;

    function automatic grid_t decode_2d(input logic [10:0] m);
        grid_t g;
        g = '0;
        g.d = 4'h1;
        g.dual = m[10];
        g.prec = m[9];
        if (m[1:0] != 2'b00) begin
            g.rcode = {m[1], m[0], m[4]};
            unique case (m[3:2])
                2'b00: begin
                    g.w = {2'b00, m[8:7]} + 4'h4;
                    g.h = {2'b00, m[6:5]} + 4'h2;
                end
                2'b01: begin
                    g.w = {2'b00, m[8:7]} + 4'h8;
                    g.h = {2'b00, m[6:5]} + 4'h2;
                end
                2'b10: begin
                    g.w = {2'b00, m[6:5]} + 4'h2;
                    g.h = {2'b00, m[8:7]} + 4'h8;
                end
                2'b11: begin
                    if (m[8]) begin
                        g.w = {3'b000, m[7]} + 4'h2;
                        g.h = {2'b00, m[6:5]} + 4'h2;
                    end else begin
                        g.w = {2'b00, m[6:5]} + 4'h2;
                        g.h = {3'b000, m[7]} + 4'h6;
                    end
                end
            endcase
        end else begin
            g.rcode = {m[3], m[2], m[4]};
            unique case (m[8:7])
                2'b00: begin
                    g.w = 4'hc;
                    g.h = {2'b00, m[6:5]} + 4'h2;
                end
                2'b01: begin
                    g.w = {2'b00, m[6:5]} + 4'h2;
                    g.h = 4'hc;
                end
                2'b11: begin
                    // Bit 6 set is void or reserved, grid left zero
                    if (!m[6]) begin
                        g.w = m[5] ? 4'ha : 4'h6;
                        g.h = m[5] ? 4'h6 : 4'ha;
                    end
                end
                2'b10: begin
                    g.w = {2'b00, m[6:5]} + 4'h6;
                    g.h = {2'b00, m[10:9]} + 4'h6;
                    g.dual = 1'b0;
                    g.prec = 1'b0;
                end
            endcase
        end
        return g;
    endfunction : decode_2d

    function automatic grid_t decode_3d(input logic [10:0] m);
        grid_t g;
        g = '0;
        g.dual = m[10];
        g.prec = m[9];
        if (m[1:0] != 2'b00) begin
            g.rcode = {m[1], m[0], m[4]};
            g.w = {2'b00, m[6:5]} + 4'h2;
            g.h = {2'b00, m[8:7]} + 4'h2;
            g.d = {2'b00, m[3:2]} + 4'h2;
        end else begin
            g.rcode = {m[3], m[2], m[4]};
            if (m[8:7] != 2'b11) begin
                g.dual = 1'b0;
                g.prec = 1'b0;
                g.w = (m[8:7] == 2'b00) ? 4'h6 : {2'b00, m[6:5]} + 4'h2;
                g.h = (m[8:7] == 2'b01) ? 4'h6 : (m[8:7] == 2'b00) ? {2'b00, m[10:9]} + 4'h2
                                                                    : {2'b00, m[10:9]} + 4'h2;
                g.d = (m[8:7] == 2'b10) ? 4'h6 : (m[8:7] == 2'b00) ? {2'b00, m[6:5]} + 4'h2
                                                                    : {2'b00, m[10:9]} + 4'h2;
                if (m[8:7] == 2'b10) begin
                    g.h = {2'b00, m[10:9]} + 4'h2;
                end
            end else if (m[6:5] != 2'b11) begin
                g.w = (m[6:5] == 2'b00) ? 4'h6 : 4'h2;
                g.h = (m[6:5] == 2'b01) ? 4'h6 : 4'h2;
                g.d = (m[6:5] == 2'b10) ? 4'h6 : 4'h2;
            end
        end
        return g;
    endfunction : decode_3d

    logic [10:0] mode;
    grid_t grid;
    range_info_t rinfo;
    logic void_c;
    logic resv_c;
    logic nan_c;
    logic dim_bad;
    logic foot_bad;
    logic [2:0] parts;
    logic [12:0] idx_count;
    logic [3:0] dmax;
    hdr_info_t hdr_nxt;

    range_decode u_range (
        .rcode(grid.rcode),
        .prec(grid.prec),
        .info(rinfo)
    );

    always_comb begin
        mode = blk_word[`MODE_MSB:`MODE_LSB];
        grid = is_3d ? decode_3d(mode) : decode_2d(mode);
        void_c = (mode[8:0] == `VOID_PATTERN);
        resv_c = (mode[8:6] == 3'b111) && (mode[1:0] == 2'b00) && !void_c;
        parts = {1'b0, blk_word[`PART_MSB:`PART_LSB]} + 3'h1;
        dmax = is_3d ? `DIM_MAX_3D : `DIM_MAX_2D;
        dim_bad = (grid.w < `DIM_MIN) || (grid.w > dmax) || (grid.h < `DIM_MIN) || (grid.h > dmax);
        if (is_3d) begin
            dim_bad = dim_bad || (grid.d < `DIM_MIN) || (grid.d > dmax);
        end
        foot_bad = (grid.w > footprint.w) || (grid.h > footprint.h) || (grid.d > footprint.d);
        idx_count = (13'(grid.w) * 13'(grid.h) * 13'(grid.d)) << grid.dual;
        nan_c = !void_c && ((mode[3:0] == 4'h0) || (idx_count > `MAX_INDICES));
        hdr_nxt = '0;
        hdr_nxt.is_void = void_c;
        hdr_nxt.is_reserved = resv_c || (mode[3:0] == 4'h0);
        hdr_nxt.nan_result = nan_c;
        hdr_nxt.part_count = parts;
        if (!void_c && !hdr_nxt.is_reserved) begin
            hdr_nxt.grid_w = grid.w;
            hdr_nxt.grid_h = grid.h;
            hdr_nxt.grid_d = grid.d;
            hdr_nxt.dual_plane = grid.dual;
            hdr_nxt.high_prec = grid.prec;
            hdr_nxt.range = rinfo;
            hdr_nxt.endpoint_pairs = parts;
            hdr_nxt.is_error = (grid.dual && parts == 3'h4) || rinfo.invalid || dim_bad || foot_bad;
            if (parts >= 3'h2) begin
                hdr_nxt.pattern_sel = blk_word[`PSEL_MSB:`PSEL_LSB];
            end else begin
                hdr_nxt.color_endpoint_mode = blk_word[`ENDPT_MODE_MSB:`ENDPT_MODE_LSB];
                if (grid.dual) begin
                    hdr_nxt.channel_sel = blk_word[`CSEL_MSB:`CSEL_LSB];
                    hdr_nxt.channel_mask = 4'h1 << blk_word[`CSEL_MSB:`CSEL_LSB];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hdr_valid <= `HDR_VALID_RST;
        end else begin
            hdr_valid <= blk_valid;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hdr <= '0;
        end else if (blk_valid) begin
            hdr <= hdr_nxt;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    AST_LATENCY: assert property (blk_valid |=> hdr_valid)
        else $error("Header not valid one cycle after block");
    AST_PART_COUNT: assert property (blk_valid |=> hdr.part_count == {1'b0, $past(blk_word[12:11])} + 3'h1)
        else $error("Partition count is not field plus one");
    AST_PATTERN: assert property (blk_valid && blk_word[12:11] != 2'b00 && mode[8:0] != `VOID_PATTERN
        && !hdr_nxt.is_reserved |=> hdr.pattern_sel == $past(blk_word[22:13]))
        else $error("Pattern selector not taken from bits 22:13");
    AST_PAIRS: assert property (blk_valid && !void_c && !hdr_nxt.is_reserved
        |=> hdr.endpoint_pairs == {1'b0, $past(blk_word[12:11])} + 3'h1)
        else $error("Endpoint pair count differs from partitions");
    AST_ENDPT_MODE: assert property (blk_valid && blk_word[12:11] == 2'b00 && !void_c && !hdr_nxt.is_reserved
        |=> hdr.color_endpoint_mode == $past(blk_word[16:13]))
        else $error("Endpoint mode not taken from bits 16:13");
    AST_DUAL_FOUR: assert property (hdr_valid && hdr.dual_plane && hdr.part_count == 3'h4 |-> hdr.is_error)
        else $error("Dual plane with four partitions not flagged");
    AST_RANGE: assert property (hdr_valid && !hdr.is_void && !hdr.is_reserved && !hdr.is_error
        |-> hdr.range.max inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h09, 5'h0b, 5'h0f,
        5'h13, 5'h17, 5'h1f})
        else $error("Legal block has an impossible index maximum");
    AST_DIMS_2D: assert property (hdr_valid && !$past(is_3d) && !hdr.is_void && !hdr.is_reserved && !hdr.is_error
        |-> hdr.grid_d == 4'h1 && hdr.grid_w >= 4'h2 && hdr.grid_w <= 4'hc)
        else $error("Legal 2D grid outside bounds");
    AST_FOOTPRINT: assert property (blk_valid && !void_c && !hdr_nxt.is_reserved && grid.w > footprint.w
        |=> hdr.is_error)
        else $error("Grid wider than footprint not flagged");
    AST_SHAPE_00: assert property (blk_valid && !is_3d && mode[1:0] != 2'b00 && mode[3:2] == 2'b00
        |=> hdr.grid_w == {2'b00, $past(blk_word[8:7])} + 4'h4)
        else $error("Width not B plus four");
    AST_VOID: assert property (blk_valid && blk_word[8:0] == 9'h1fc |=> hdr.is_void && !hdr.is_error)
        else $error("Void-extent block not recognised");
    AST_NAN: assert property (blk_valid && blk_word[3:0] == 4'h0 |=> hdr.nan_result && hdr.is_reserved)
        else $error("Zero low mode bits did not yield NaN");
    AST_CHANNEL: assert property (hdr_valid && hdr.dual_plane && hdr.part_count == 3'h1 && !hdr.is_void
        |-> hdr.channel_mask == (4'h1 << $past(blk_word[18:17])))
        else $error("Channel mask does not match channel select");

endmodule : texture_block_header_decoder
